// ===== verilog/spi_mem_slave.sv
// Serial peripheral bus slave front end of a byte-addressed memory.
`timescale 1ns/1ps
`default_nettype none
module spi_mem_slave
  import fram_spi_pkg::*;
#(
  parameter int AW = ADDR_W
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic cs_n,
  input  wire logic sclk,
  input  wire logic mosi,
  input  wire logic hold_n,
  input  wire logic wp_n,
  output var  logic miso,
  output var  logic miso_oe
);

  typedef struct packed {
    logic [2:0]        cs_s;
    logic [2:0]        sclk_s;
    logic [2:0]        mosi_s;
    logic [2:0]        hold_s;
    logic [2:0]        wp_s;
    logic              cs_f;
    logic              sclk_f;
    logic              mosi_f;
    logic              hold_f;
    logic              wp_f;
    logic              sclk_p;
    logic              cs_act;
    logic              mode3;
    logic              seen_rise;
    logic              drv;
    phase_t            phase;
    logic [2:0]        bitcnt;
    logic [7:0]        sh;
    logic [7:0]        out_byte;
    logic [7:0]        status;
    logic [AW-1:0]     addr;
    logic [AW-1:0]     mem_addr;
    logic [DATA_W-1:0] mem_wd;
    logic              mem_we;
    logic              mem_re;
    logic              rd_pend;
    logic              miso;
    logic              oe;
  } slave_st_t;

  slave_st_t         st_ff;
  slave_st_t         nxt_st;
  logic [DATA_W-1:0] mem_rdata;
  logic              rise_w;
  logic              fall_w;
  logic [7:0]        in_byte;

  // A pin level is accepted once the second and third stages agree.
  function automatic logic filt(input logic [2:0] s, input logic cur);
    return (s[1] == s[2]) ? s[2] : cur;
  endfunction

  // Next byte address; the top address wraps round to zero.
  function automatic logic [AW-1:0] addr_inc(input logic [AW-1:0] a);
    return a + AW'(1);
  endfunction

  byte_store #(
    .AW (AW),
    .DW (DATA_W)
  ) u_store (
    .clk     (core_clk),
    .wr_en   (st_ff.mem_we),
    .rd_en   (st_ff.mem_re),
    .addr    (st_ff.mem_addr),
    .wr_data (st_ff.mem_wd),
    .rd_data (mem_rdata)
  );

  // Clock edges count only inside an active, unheld selection.
  assign rise_w  = st_ff.sclk_f & ~st_ff.sclk_p & st_ff.hold_f & ~st_ff.cs_act;
  assign fall_w  = ~st_ff.sclk_f & st_ff.sclk_p & st_ff.hold_f & ~st_ff.cs_act;
  assign in_byte = {st_ff.sh[6:0], st_ff.mosi_f};

  // Next-state logic: pin filtering, framing, command decode and shifting.
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.cs_s   = {st_ff.cs_s[1:0], cs_n};
    nxt_st.sclk_s = {st_ff.sclk_s[1:0], sclk};
    nxt_st.mosi_s = {st_ff.mosi_s[1:0], mosi};
    nxt_st.hold_s = {st_ff.hold_s[1:0], hold_n};
    nxt_st.wp_s   = {st_ff.wp_s[1:0], wp_n};
    nxt_st.cs_f   = filt(st_ff.cs_s, st_ff.cs_f);
    nxt_st.sclk_f = filt(st_ff.sclk_s, st_ff.sclk_f);
    nxt_st.mosi_f = filt(st_ff.mosi_s, st_ff.mosi_f);
    nxt_st.hold_f = filt(st_ff.hold_s, st_ff.hold_f);
    nxt_st.wp_f   = filt(st_ff.wp_s, st_ff.wp_f);
    nxt_st.sclk_p = st_ff.sclk_f;
    nxt_st.mem_we  = 1'b0;
    nxt_st.mem_re  = 1'b0;
    nxt_st.rd_pend = st_ff.mem_re;
    // Read data is back two cycles after the request, well before a fall.
    if (st_ff.rd_pend) begin
      nxt_st.out_byte = mem_rdata;
    end
    // Select edges are taken only while hold is high; a select change
    // during hold is seen once hold is released.
    if (st_ff.hold_f && (st_ff.cs_f != st_ff.cs_act)) begin
      nxt_st.cs_act = st_ff.cs_f;
      nxt_st.bitcnt = 3'h0;
      nxt_st.drv    = 1'b0;
      if (!st_ff.cs_f) begin
        nxt_st.phase     = PH_CMD;
        nxt_st.mode3     = st_ff.sclk_f;
        nxt_st.seen_rise = 1'b0;
      end else begin
        // Completing a write operation drops the write enable.
        if (st_ff.phase == PH_ARRAY_WR || st_ff.phase == PH_STAT_WR) begin
          nxt_st.status[STAT_WEL_BIT] = 1'b0;
        end
        nxt_st.phase = PH_IDLE;
      end
    end else if (rise_w) begin
      nxt_st.sh        = in_byte;
      nxt_st.bitcnt    = 3'(st_ff.bitcnt + 3'h1);
      nxt_st.seen_rise = 1'b1;
      if (st_ff.phase == PH_ADDR_HI || st_ff.phase == PH_ADDR_LO) begin
        nxt_st.addr = {st_ff.addr[AW-2:0], st_ff.mosi_f};
        // The shifter keeps the command byte, so the last address bit can
        // still tell a read from a write.
        nxt_st.sh   = st_ff.sh;
      end
      if (st_ff.bitcnt == LAST_BIT) begin
        case (st_ff.phase)
          PH_CMD: begin
            // The first byte is the command; later bytes never re-decode.
            case (in_byte)
              CMD_ARRAY_RD, CMD_ARRAY_WR: begin
                nxt_st.phase = PH_ADDR_HI;
                nxt_st.sh    = in_byte;
              end
              CMD_SET_WEL: begin
                nxt_st.status[STAT_WEL_BIT] = 1'b1;
                nxt_st.phase = PH_DONE;
              end
              CMD_CLR_WEL: begin
                nxt_st.status[STAT_WEL_BIT] = 1'b0;
                nxt_st.phase = PH_DONE;
              end
              CMD_STAT_RD: begin
                nxt_st.out_byte = st_ff.status;
                nxt_st.phase    = PH_STAT_RD;
              end
              CMD_STAT_WR: nxt_st.phase = PH_STAT_WR;
              default:     nxt_st.phase = PH_DONE;
            endcase
          end
          PH_ADDR_HI: begin
            nxt_st.phase = PH_ADDR_LO;
            nxt_st.sh    = st_ff.sh;
          end
          PH_ADDR_LO: begin
            if (st_ff.sh == CMD_ARRAY_RD) begin
              nxt_st.phase    = PH_ARRAY_RD;
              nxt_st.mem_re   = 1'b1;
              nxt_st.mem_addr = {st_ff.addr[AW-2:0], st_ff.mosi_f};
              nxt_st.addr     = addr_inc({st_ff.addr[AW-2:0], st_ff.mosi_f});
            end else begin
              nxt_st.phase = PH_ARRAY_WR;
            end
          end
          PH_ARRAY_RD: begin
            // Prefetch the next byte; the address wraps at the top.
            nxt_st.mem_re   = 1'b1;
            nxt_st.mem_addr = st_ff.addr;
            nxt_st.addr     = addr_inc(st_ff.addr);
          end
          PH_ARRAY_WR: begin
            // Array writes ignore the write-protect pin by design.
            if (st_ff.status[STAT_WEL_BIT]) begin
              nxt_st.mem_we   = 1'b1;
              nxt_st.mem_addr = st_ff.addr;
              nxt_st.mem_wd   = in_byte;
            end
            nxt_st.addr = addr_inc(st_ff.addr);
          end
          PH_STAT_WR: begin
            if (st_ff.status[STAT_WEL_BIT] && st_ff.wp_f) begin
              nxt_st.status = (st_ff.status & ~STAT_WR_MASK)
                            | (in_byte & STAT_WR_MASK);
            end
            // A status write is a write operation and drops the enable.
            nxt_st.status[STAT_WEL_BIT] = 1'b0;
            nxt_st.phase = PH_DONE;
          end
          PH_STAT_RD: nxt_st.out_byte = st_ff.status;
          default:    nxt_st.phase = st_ff.phase;
        endcase
      end
    end else if (fall_w && !(st_ff.mode3 && !st_ff.seen_rise)) begin
      // In mode 3 the fall before the first rise carries no data.
      if (st_ff.phase == PH_ARRAY_RD || st_ff.phase == PH_STAT_RD) begin
        nxt_st.miso = st_ff.out_byte[3'(LAST_BIT - st_ff.bitcnt)];
        nxt_st.drv  = 1'b1;
      end
    end
    // Driving starts at the first data fall so a shared line is free.
    nxt_st.oe = nxt_st.drv && !nxt_st.cs_act && !nxt_st.cs_f
              && nxt_st.hold_f;
    if (!rst_n) begin
      nxt_st        = '0;
      nxt_st.cs_s   = SYNC_HIGH;
      nxt_st.hold_s = SYNC_HIGH;
      nxt_st.wp_s   = SYNC_HIGH;
      nxt_st.cs_f   = 1'b1;
      nxt_st.hold_f = 1'b1;
      nxt_st.wp_f   = 1'b1;
      nxt_st.cs_act = 1'b1;
      nxt_st.phase  = PH_IDLE;
      nxt_st.status = STAT_RESET;
    end
  end

  // All state advances on every edge; nothing depends on clock speed
  // beyond the sampling margin, so the link clock may stop anywhere.
  always_ff @(posedge core_clk) begin
    st_ff <= nxt_st;
  end

  assign miso    = st_ff.miso;
  assign miso_oe = st_ff.oe;

  // Checks on the framing and pin behaviour.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_standby_quiet: assert property (st_ff.cs_f |-> !miso_oe)
    else $error("output driven while deselected");
  a_sel_gates_clk: assert property (
    st_ff.cs_act && st_ff.cs_f && st_ff.hold_f
    |=> st_ff.phase == PH_IDLE)
    else $error("activity while chip select is high");
  a_hold_freeze: assert property (
    !st_ff.hold_f && !$past(st_ff.hold_f)
    |-> $stable(st_ff.phase) && $stable(st_ff.bitcnt))
    else $error("state moved during hold");
  a_hold_release: assert property (!st_ff.hold_f |-> !miso_oe)
    else $error("output driven during hold");
  a_out_on_fall: assert property (
    $changed(st_ff.miso) |-> $past(fall_w))
    else $error("output changed without a falling edge");
  a_status_wp: assert property (
    ((st_ff.status & STAT_WR_MASK) != ($past(st_ff.status) & STAT_WR_MASK))
    |-> $past(st_ff.wp_f))
    else $error("status written while protected");
  a_write_commit: assert property (
    rise_w && st_ff.phase == PH_ARRAY_WR && st_ff.bitcnt == LAST_BIT
    && st_ff.status[STAT_WEL_BIT]
    |=> st_ff.mem_we && st_ff.mem_wd == $past(in_byte))
    else $error("written byte not committed at once");
  a_addr_msb_first: assert property (
    rise_w && (st_ff.phase == PH_ADDR_HI || st_ff.phase == PH_ADDR_LO)
    |=> (st_ff.phase == PH_ARRAY_RD ? st_ff.mem_addr : st_ff.addr)
        == {$past(st_ff.addr[AW-2:0]), $past(st_ff.mosi_f)})
    else $error("address not shifted most significant bit first");
  a_mode_capture: assert property (
    st_ff.hold_f && st_ff.cs_act && !st_ff.cs_f
    |=> st_ff.mode3 == $past(st_ff.sclk_f))
    else $error("clock mode not taken at select fall");
  a_bit_count: assert property (
    rise_w && !(st_ff.hold_f && st_ff.cs_f != st_ff.cs_act)
    |=> st_ff.bitcnt == 3'($past(st_ff.bitcnt) + 3'h1))
    else $error("bit counter did not advance");
  a_one_command: assert property (
    st_ff.phase == PH_DONE && !st_ff.cs_f |=> st_ff.phase == PH_DONE)
    else $error("second command accepted in one selection");

  c_array_read:  cover property (st_ff.phase == PH_ARRAY_RD && miso_oe);
  c_array_write: cover property (st_ff.mem_we);
  c_hold_pause:  cover property (!st_ff.hold_f && !st_ff.cs_act);
  c_mode3_sel:   cover property (st_ff.mode3 && st_ff.phase == PH_CMD);

endmodule
`default_nettype wire

// ===== verilog/fram_spi_pkg.sv
// Shared constants and types for the serial memory slave front end.
package fram_spi_pkg;

  // Array geometry.
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // Command byte values.
  localparam logic [7:0] CMD_SET_WEL   = 8'h06;
  localparam logic [7:0] CMD_CLR_WEL   = 8'h04;
  localparam logic [7:0] CMD_STAT_RD   = 8'h05;
  localparam logic [7:0] CMD_STAT_WR   = 8'h01;
  localparam logic [7:0] CMD_ARRAY_RD  = 8'h03;
  localparam logic [7:0] CMD_ARRAY_WR  = 8'h02;

  // Status register layout and reset value.
  localparam logic [7:0] STAT_RESET    = 8'h40;
  localparam logic [7:0] STAT_WR_MASK  = 8'h8C;
  localparam int         STAT_WEL_BIT  = 1;

  // Bit position of the last bit in a byte.
  localparam logic [2:0] LAST_BIT      = 3'h7;

  // Reset levels of the filtered pins.
  localparam logic [2:0] SYNC_HIGH     = 3'h7;

  // Transaction phases within one chip-select assertion.
  typedef enum logic [3:0] {
    PH_IDLE,
    PH_CMD,
    PH_ADDR_HI,
    PH_ADDR_LO,
    PH_ARRAY_RD,
    PH_ARRAY_WR,
    PH_STAT_RD,
    PH_STAT_WR,
    PH_DONE
  } phase_t;

endpackage

// ===== verilog/byte_store.sv
// Byte-wide storage array with registered read data.
`timescale 1ns/1ps
`default_nettype none
module byte_store #(
  parameter int AW = 16,
  parameter int DW = 8
) (
  input  wire logic          clk,
  input  wire logic          wr_en,
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wr_data,
  output var  logic [DW-1:0] rd_data
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Writes land in the same edge they are presented; no busy time exists.
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[addr];
    end
  end

endmodule
`default_nettype wire

// ===== testbench/spi_host_model.sv
// Host bus master model that drives the serial memory slave pins.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input  wire logic core_clk,
  output var  logic cs_n,
  output var  logic sclk,
  output var  logic host_d,
  output var  logic host_oe,
  output var  logic hold_n
);
  // Pins idle with the select high and the host off the data line.
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    host_d = 1'b0;
    host_oe = 1'b0;
    hold_n = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // The idle clock level before the select falls picks the mode.
  task automatic sel(input logic m);
    sclk <= m;
    tick(4);
    cs_n <= 1'b0;
    tick(4);
  endtask

  // A final fall lets the last read bit be sampled, then the clock parks.
  task automatic desel(input logic m);
    sclk <= 1'b0;
    tick(4);
    cs_n <= 1'b1;
    tick(1);
    sclk <= m;
    tick(6);
  endtask

  // Data moves mid low phase so it is stable well past each rise.
  task automatic xb(input logic [7:0] b, input logic drv, input logic hld);
    for (int i = 7; i >= 0; i--) begin
      sclk <= 1'b0;
      tick(2);
      host_oe <= drv;
      host_d <= b[i];
      tick(2);
      if (hld && i == 4) begin
        hold_n <= 1'b0;
        tick(4);
        repeat (2) begin
          sclk <= 1'b1;
          tick(4);
          sclk <= 1'b0;
          tick(4);
        end
        hold_n <= 1'b1;
        tick(6);
      end
      sclk <= 1'b1;
      tick(4);
    end
  endtask

  // Clock and data wiggle with the select high; the slave must not react.
  task automatic noise();
    repeat (6) begin
      sclk <= ~sclk;
      host_oe <= 1'b1;
      host_d <= 1'($urandom);
      tick(4);
    end
  endtask
endmodule
`default_nettype wire

// ===== testbench/spi_mem_slave_tb_top.sv
// Self-checking bench for the serial memory slave with one shared data line.
`timescale 1ns/1ps
`default_nettype none
module spi_mem_slave_tb_top;
  import fram_spi_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wp_n = 1'b1;
  logic float_v = 1'b0;
  wire logic cs_n, sclk, host_d, host_oe, hold_n, miso, miso_oe, dq;
  int num_errors = 0;
  int compares = 0;
  int nb = 0;
  int hc = 0;
  int cc = 0;
  logic [7:0] sh;
  logic [7:0] exp_q[$];
  logic [7:0] shadow[logic [15:0]];

  // A released line shows a toggling pattern, never a stale level.
  assign dq = miso_oe ? miso : (host_oe ? host_d : float_v);

  spi_mem_slave spi_mem_slave_inst (.core_clk(core_clk), .rst_n(rst_n),
    .cs_n(cs_n), .sclk(sclk), .mosi(dq), .hold_n(hold_n), .wp_n(wp_n),
    .miso(miso), .miso_oe(miso_oe));
  spi_host_model spi_host_model_inst (.core_clk(core_clk), .cs_n(cs_n),
    .sclk(sclk), .host_d(host_d), .host_oe(host_oe), .hold_n(hold_n));

  initial begin
    forever #25 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [7:0] e, s);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic give_verdict();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Read bits are taken just before the fall that would replace them.
  always @(negedge sclk) begin
    if (miso_oe === 1'b1 && hold_n === 1'b1 && cs_n === 1'b0) begin
      sh = {sh[6:0], dq};
      nb++;
      if (nb == 8) begin
        nb = 0;
        if (exp_q.size() == 0) check("extra byte", 8'hXX, sh);
        else check("read byte", exp_q.pop_front(), sh);
      end
    end
  end

  // Enable must drop during hold and standby and never fight the host.
  always @(posedge core_clk) begin
    hc <= hold_n ? 0 : hc + 1;
    cc <= cs_n ? cc + 1 : 0;
    float_v <= ~float_v;
    if (hc == 6) check("oe in hold", 8'h00, {7'h00, miso_oe});
    if (cc == 6) check("oe in standby", 8'h00, {7'h00, miso_oe});
    if (miso_oe === 1'b1 && host_oe === 1'b1)
      check("line conflict", 8'h00, 8'h01);
  end

  task automatic cmd(input logic m, input logic [7:0] op);
    spi_host_model_inst.sel(m);
    spi_host_model_inst.xb(op, 1'b1, 1'b0);
    spi_host_model_inst.desel(m);
  endtask

  task automatic stat_rd(input logic m, input logic [7:0] e);
    exp_q.push_back(e);
    spi_host_model_inst.sel(m);
    spi_host_model_inst.xb(CMD_STAT_RD, 1'b1, 1'b0);
    spi_host_model_inst.xb(8'h00, 1'b0, 1'b0);
    spi_host_model_inst.desel(m);
  endtask

  // The status write itself must leave the write enable clear.
  task automatic stat_wr(input logic [7:0] v);
    cmd(1'b0, CMD_SET_WEL);
    spi_host_model_inst.sel(1'b0);
    spi_host_model_inst.xb(CMD_STAT_WR, 1'b1, 1'b0);
    spi_host_model_inst.xb(v, 1'b1, 1'b0);
    spi_host_model_inst.desel(1'b0);
  endtask

  // Address goes upper byte first; the shadow learns only enabled writes.
  task automatic xfer(input logic m, rd, we, hld, input logic [15:0] a,
                      input int n);
    logic [7:0] d;
    if (we) cmd(m, CMD_SET_WEL);
    spi_host_model_inst.sel(m);
    spi_host_model_inst.xb(rd ? CMD_ARRAY_RD : CMD_ARRAY_WR, 1'b1, 1'b0);
    spi_host_model_inst.xb(a[15:8], 1'b1, 1'b0);
    spi_host_model_inst.xb(a[7:0], 1'b1, 1'b0);
    for (int i = 0; i < n; i++) begin
      d = rd ? 8'h00 : 8'($urandom);
      if (rd) exp_q.push_back(shadow[16'(a + i)]);
      else if (we) shadow[16'(a + i)] = d;
      spi_host_model_inst.xb(d, !rd, hld && i == 0);
    end
    spi_host_model_inst.desel(m);
  endtask

  initial begin
    logic [7:0] r13[5];
    void'($urandom(38));
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    stat_rd(1'b0, STAT_RESET);
    spi_host_model_inst.noise();
    stat_rd(1'b1, STAT_RESET);
    xfer(1'b1, 1'b0, 1'b1, 1'b0, 16'hFFFF, 3);
    xfer(1'b0, 1'b1, 1'b0, 1'b0, 16'hFFFF, 3);
    xfer(1'b0, 1'b0, 1'b0, 1'b0, 16'hFFFF, 2);
    xfer(1'b1, 1'b1, 1'b0, 1'b0, 16'hFFFF, 2);
    wp_n <= 1'b0;
    stat_wr(8'h8C);
    stat_rd(1'b0, STAT_RESET);
    xfer(1'b0, 1'b0, 1'b1, 1'b0, 16'h1234, 1);
    xfer(1'b0, 1'b1, 1'b0, 1'b0, 16'h1234, 1);
    wp_n <= 1'b1;
    stat_wr(8'h8C);
    stat_rd(1'b0, (STAT_RESET & ~STAT_WR_MASK) | (8'h8C & STAT_WR_MASK));
    r13 = '{CMD_SET_WEL, CMD_ARRAY_WR, 8'h12, 8'h34, ~shadow[16'h1234]};
    spi_host_model_inst.sel(1'b0);
    foreach (r13[i]) spi_host_model_inst.xb(r13[i], 1'b1, 1'b0);
    spi_host_model_inst.desel(1'b0);
    xfer(1'b0, 1'b1, 1'b0, 1'b0, 16'h1234, 1);
    cmd(1'b0, CMD_CLR_WEL);
    xfer(1'b0, 1'b1, 1'b0, 1'b1, 16'hFFFF, 3);
    repeat (20) @(posedge core_clk);
    check("bytes left", 8'h00, 8'(exp_q.size()));
    give_verdict();
  end

  // About 4400 cycles of traffic; the limit leaves ample headroom.
  initial begin
    repeat (40000) @(posedge core_clk);
    num_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
